// [design/dpms_pkg.sv]
/*
  Package of the deflection power mode sequencer: modes, register layout,
  reset values, ramp timing and the structs that carry grouped signals.
  Assumes a 100 MHz clock and a single I2C-style write port feeding it.
*/
package dpms_pkg;

  localparam int unsigned CLK_MHZ          = 100;
  localparam logic [6:0]  MODE_REG_SAD     = 7'h1A;
  localparam logic        BUFFERED_MSB     = 1'h1;
  localparam int unsigned PDR_BIT          = 0;
  localparam int unsigned REL_BIT          = 1;
  localparam logic        PDR_RESET        = 1'h1;
  localparam logic        REL_RESET        = 1'h0;
  localparam logic [7:0]  DUTY_MAX         = 8'hFF;
  localparam logic [7:0]  DUTY_MIN         = 8'h00;
  // One microsecond per step keeps a full ramp near 0.26 ms, so full
  // operation is reachable in a short run; slower supplies need more.
  localparam int unsigned RAMP_STEP_US     = 1;
  localparam int unsigned RAMP_STEP_CYCLES = RAMP_STEP_US * CLK_MHZ;
  localparam logic [15:0] RAMP_STEP_LAST   =
    16'(RAMP_STEP_CYCLES - 1);

  typedef enum logic [2:0] {
    DPMS_POR       = 3'h0,
    DPMS_STANDBY   = 3'h1,
    DPMS_SUPPLY_ON = 3'h2,
    DPMS_SOFTSTART = 3'h3,
    DPMS_OPERATE   = 3'h4,
    DPMS_SOFTDOWN  = 3'h5,
    DPMS_PROTECT   = 3'h6
  } dpms_mode_t;

  typedef struct packed {
    logic       valid;
    logic       buffered;
    logic [6:0] subaddr;
    logic [7:0] data;
  } dpms_write_t;

  typedef struct packed {
    logic supply_ok;
    logic dip_upper;
    logic dip_lower;
    logic fault;
    logic sync_locked;
  } dpms_sense_t;

  typedef struct packed {
    logic [7:0] line_duty;
    logic [7:0] supply_duty;
    logic       line_oe;
    logic       supply_oe;
  } dpms_drive_t;

endpackage : dpms_pkg

// [design/dpms_ramp.sv]
/*
  Duty ramp generator: steps a duty value up or down by one per tick.
  Assumes the caller supplies a one-cycle step tick and a direction.
*/
`timescale 1ns/1ns
module dpms_ramp (
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  input  wire logic       tick_i,
  input  wire logic       up_i,
  input  wire logic       run_i,
  input  wire logic       clear_i,
  output logic      [7:0] duty_o,
  output logic            at_top_o,
  output logic            at_bottom_o
);
  typedef struct packed {
    logic [7:0] duty;
  } dpms_ramp_state_t;

  dpms_ramp_state_t state;
  dpms_ramp_state_t next_state;

  always_comb begin
    next_state = state;
    if (clear_i) begin
      next_state.duty = dpms_pkg::DUTY_MIN;
    end else if (run_i && tick_i) begin
      if (up_i && state.duty != dpms_pkg::DUTY_MAX) begin
        next_state.duty = state.duty + 8'h01;
      end else if (!up_i && state.duty != dpms_pkg::DUTY_MIN) begin
        next_state.duty = state.duty - 8'h01;
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign duty_o      = state.duty;
  assign at_top_o    = (state.duty == dpms_pkg::DUTY_MAX);
  assign at_bottom_o = (state.duty == dpms_pkg::DUTY_MIN);
endmodule : dpms_ramp

// [design/dpms_sequencer.sv]
/*
  Operating-mode sequencer of a deflection controller: power-on reset,
  standby, supply enable, soft start, operation, soft down, protection.
  Assumes writes arrive decoded from the serial bus, one per transfer,
  and that supply and fault sense inputs are synchronous to clock_i.
*/
`timescale 1ns/1ns
module dpms_sequencer (
  input  wire logic                  clock_i,
  input  wire logic                  reset_n_i,
  input  wire dpms_pkg::dpms_write_t write_i,
  input  wire dpms_pkg::dpms_sense_t sense_i,
  input  wire logic                  prot_clear_i,
  output logic                       ack_enable_o,
  output logic                       supply_enable_o,
  output logic                       vertical_enable_o,
  output dpms_pkg::dpms_drive_t      drive_o,
  output logic                       sync_unlock_flag_o,
  output logic                       sync_unlock_oe_o,
  output logic                       clamp_blank_out_o,
  output logic                       sync_lock_loop_en_o,
  output logic                       phase_loop_en_o,
  output logic                       regs_valid_o,
  output dpms_pkg::dpms_mode_t       mode_o
);

  typedef struct packed {
    dpms_pkg::dpms_mode_t  mode;
    logic                  power_down_request_bit;
    logic                  drive_release_bit;
    logic                  dip_restart;
    logic                  regs_valid;
    logic [15:0]           step_count;
    logic                  ack_enable;
    logic                  supply_enable;
    logic                  vertical_enable;
    dpms_pkg::dpms_drive_t drive;
    logic                  unlock_flag;
    logic                  unlock_oe;
    logic                  blank;
    logic                  loops_en;
  } dpms_seq_state_t;

  dpms_seq_state_t state;
  dpms_seq_state_t next_state;

  logic       tick;
  logic       line_up;
  logic       line_run;
  logic       line_clear;
  logic       supply_up;
  logic       supply_run;
  logic       supply_clear;
  logic [7:0] line_duty;
  logic [7:0] supply_duty;
  logic       line_top;
  logic       line_bottom;
  logic       supply_top;
  logic       supply_bottom;
  logic       mode_write;

  // A mode bit write is recognised at either the direct or buffered alias.
  function automatic logic hits_mode_reg(input dpms_pkg::dpms_write_t w);
    return w.valid && w.subaddr == dpms_pkg::MODE_REG_SAD;
  endfunction : hits_mode_reg

  assign tick       = (state.step_count == dpms_pkg::RAMP_STEP_LAST);
  // Every valid write carries exactly one byte for one subaddress.
  assign mode_write = hits_mode_reg(write_i);

  generate
    genvar g;
    for (g = 0; g < 2; g++) begin : g_ramp
      logic d_up;
      logic d_run;
      logic d_clear;
      logic [7:0] d_duty;
      logic d_top;
      logic d_bot;
      assign d_up    = (g == 0) ? line_up : supply_up;
      assign d_run   = (g == 0) ? line_run : supply_run;
      assign d_clear = (g == 0) ? line_clear : supply_clear;
      dpms_ramp u_ramp (
        .clock_i     (clock_i),
        .reset_n_i   (reset_n_i),
        .tick_i      (tick),
        .up_i        (d_up),
        .run_i       (d_run),
        .clear_i     (d_clear),
        .duty_o      (d_duty),
        .at_top_o    (d_top),
        .at_bottom_o (d_bot)
      );
    end
  endgenerate

  assign line_duty     = g_ramp[0].d_duty;
  assign line_top      = g_ramp[0].d_top;
  assign line_bottom   = g_ramp[0].d_bot;
  assign supply_duty   = g_ramp[1].d_duty;
  assign supply_top    = g_ramp[1].d_top;
  assign supply_bottom = g_ramp[1].d_bot;

  always_comb begin
    line_up      = 1'h0;
    line_run     = 1'h0;
    line_clear   = 1'h0;
    supply_up    = 1'h0;
    supply_run   = 1'h0;
    supply_clear = 1'h0;
    case (state.mode)
      dpms_pkg::DPMS_SOFTSTART: begin
        line_up    = 1'h1;
        line_run   = 1'h1;
        supply_up  = 1'h1;
        supply_run = 1'h1;
      end
      dpms_pkg::DPMS_SOFTDOWN: begin
        // Supply drive first; the line drive follows once it is down.
        supply_run = 1'h1;
        line_run   = supply_bottom;
      end
      dpms_pkg::DPMS_OPERATE: begin
      end
      default: begin
        line_clear   = 1'h1;
        supply_clear = 1'h1;
      end
    endcase
    if (sense_i.dip_lower || !sense_i.supply_ok) begin
      line_clear   = 1'h1;
      supply_clear = 1'h1;
    end
  end

  always_comb begin
    next_state = state;
    next_state.step_count = tick ? 16'h0000 : state.step_count + 16'h0001;

    // Host writes to the mode register; ignored in power-on reset.
    if (mode_write && state.mode != dpms_pkg::DPMS_POR) begin
      next_state.power_down_request_bit = write_i.data[dpms_pkg::PDR_BIT];
      // A release request is dropped while the upper dip is active.
      if (!(sense_i.dip_upper && write_i.data[dpms_pkg::REL_BIT])) begin
        next_state.drive_release_bit = write_i.data[dpms_pkg::REL_BIT];
      end
    end
    if (write_i.valid && !mode_write && state.mode != dpms_pkg::DPMS_POR
        && state.mode != dpms_pkg::DPMS_STANDBY) begin
      next_state.regs_valid = 1'h1;
    end
    if (prot_clear_i) begin
      next_state.power_down_request_bit = 1'h0;
      next_state.drive_release_bit      = 1'h0;
    end

    case (state.mode)
      dpms_pkg::DPMS_POR: begin
        next_state.power_down_request_bit = dpms_pkg::PDR_RESET;
        next_state.drive_release_bit      = dpms_pkg::REL_RESET;
        if (sense_i.supply_ok) begin
          next_state.mode = dpms_pkg::DPMS_STANDBY;
        end
      end
      dpms_pkg::DPMS_STANDBY: begin
        if (!next_state.power_down_request_bit) begin
          next_state.mode = dpms_pkg::DPMS_SUPPLY_ON;
        end
      end
      dpms_pkg::DPMS_SUPPLY_ON: begin
        if (next_state.power_down_request_bit) begin
          next_state.mode = dpms_pkg::DPMS_STANDBY;
        end else if (next_state.drive_release_bit) begin
          next_state.mode = dpms_pkg::DPMS_SOFTSTART;
        end
      end
      dpms_pkg::DPMS_SOFTSTART: begin
        if (!next_state.drive_release_bit) begin
          next_state.mode = dpms_pkg::DPMS_SOFTDOWN;
        end else if (line_top && supply_top) begin
          next_state.mode = dpms_pkg::DPMS_OPERATE;
        end
      end
      dpms_pkg::DPMS_OPERATE: begin
        if (sense_i.fault) begin
          next_state.mode = dpms_pkg::DPMS_PROTECT;
        end else if (sense_i.dip_upper) begin
          next_state.dip_restart = 1'h1;
          next_state.mode        = dpms_pkg::DPMS_SOFTDOWN;
        end else if (!next_state.drive_release_bit) begin
          next_state.mode = dpms_pkg::DPMS_SOFTDOWN;
        end
      end
      dpms_pkg::DPMS_SOFTDOWN: begin
        if (supply_bottom && line_bottom) begin
          if (state.dip_restart && !sense_i.dip_upper) begin
            next_state.dip_restart = 1'h0;
            next_state.mode        = dpms_pkg::DPMS_SOFTSTART;
          end else if (!state.dip_restart) begin
            next_state.mode = next_state.power_down_request_bit
                            ? dpms_pkg::DPMS_STANDBY
                            : dpms_pkg::DPMS_SUPPLY_ON;
          end
        end
      end
      dpms_pkg::DPMS_PROTECT: begin
        if (mode_write && next_state.drive_release_bit) begin
          next_state.mode = dpms_pkg::DPMS_SOFTSTART;
        end else if (!next_state.drive_release_bit
                     && next_state.power_down_request_bit) begin
          next_state.mode = dpms_pkg::DPMS_STANDBY;
        end
      end
      default: begin
        next_state.mode = dpms_pkg::DPMS_POR;
      end
    endcase

    // A deep dip or loss of supply wins over every other transition.
    if (!sense_i.supply_ok) begin
      next_state.mode = dpms_pkg::DPMS_POR;
      next_state.dip_restart = 1'h0;
    end else if (sense_i.dip_lower && state.mode != dpms_pkg::DPMS_POR) begin
      next_state.mode        = dpms_pkg::DPMS_STANDBY;
      next_state.dip_restart = 1'h0;
    end

    // Contents are dropped on the very edge that enters standby.
    if (next_state.mode inside {dpms_pkg::DPMS_POR,
                                dpms_pkg::DPMS_STANDBY}) begin
      next_state.regs_valid = 1'h0;
    end

    // Outputs are registered from the next mode so they follow it exactly.
    next_state.ack_enable = (next_state.mode != dpms_pkg::DPMS_POR);
    next_state.supply_enable =
      !(next_state.mode inside {dpms_pkg::DPMS_POR,
                                dpms_pkg::DPMS_STANDBY});
    next_state.vertical_enable = next_state.supply_enable &&
      next_state.mode != dpms_pkg::DPMS_PROTECT;
    next_state.drive.line_duty   = line_duty;
    next_state.drive.supply_duty = supply_duty;
    next_state.drive.line_oe = next_state.mode inside
      {dpms_pkg::DPMS_SOFTSTART, dpms_pkg::DPMS_OPERATE,
       dpms_pkg::DPMS_SOFTDOWN};
    next_state.drive.supply_oe = next_state.drive.line_oe;
    next_state.loops_en = next_state.mode inside
      {dpms_pkg::DPMS_SOFTSTART, dpms_pkg::DPMS_OPERATE};
    next_state.blank = (next_state.mode == dpms_pkg::DPMS_PROTECT);
    next_state.unlock_oe = (next_state.mode != dpms_pkg::DPMS_PROTECT);
    // Flag drops only in full operation once the loop reports lock.
    next_state.unlock_flag = !(next_state.mode == dpms_pkg::DPMS_OPERATE
                               && sense_i.sync_locked);
  end

  // All state is cleared at reset; the mode, the mode bits, the unlock
  // flag and its output enable then take their reset values.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state                        <= '0;
      state.mode                   <= dpms_pkg::DPMS_POR;
      state.power_down_request_bit <= dpms_pkg::PDR_RESET;
      state.drive_release_bit      <= dpms_pkg::REL_RESET;
      state.unlock_flag            <= 1'h1;
      state.unlock_oe              <= 1'h1;
    end else begin
      state <= next_state;
    end
  end

  assign ack_enable_o        = state.ack_enable;
  assign supply_enable_o     = state.supply_enable;
  assign vertical_enable_o   = state.vertical_enable;
  assign drive_o             = state.drive;
  assign sync_unlock_flag_o  = state.unlock_flag;
  assign sync_unlock_oe_o    = state.unlock_oe;
  assign clamp_blank_out_o   = state.blank;
  assign sync_lock_loop_en_o = state.loops_en;
  assign phase_loop_en_o     = state.loops_en;
  assign regs_valid_o        = state.regs_valid;
  assign mode_o              = state.mode;

endmodule : dpms_sequencer

// [verification/dpms_monitor.sv]
/*
  Checker of the mode sequencer, watching only its top-level ports.
  Assumes one clock domain and the asynchronous active-low reset.
*/
`timescale 1ns/1ns
module dpms_monitor (
  input wire logic                  clock_i,
  input wire logic                  reset_n_i,
  input wire dpms_pkg::dpms_write_t write_i,
  input wire dpms_pkg::dpms_sense_t sense_i,
  input wire logic                  prot_clear_i,
  input wire logic                  ack_enable_o,
  input wire logic                  supply_enable_o,
  input wire logic                  vertical_enable_o,
  input wire dpms_pkg::dpms_drive_t drive_o,
  input wire logic                  sync_unlock_flag_o,
  input wire logic                  sync_unlock_oe_o,
  input wire logic                  clamp_blank_out_o,
  input wire logic                  sync_lock_loop_en_o,
  input wire logic                  phase_loop_en_o,
  input wire logic                  regs_valid_o,
  input wire dpms_pkg::dpms_mode_t  mode_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  logic rel_wr;
  assign rel_wr = write_i.valid && write_i.subaddr == 7'h1A
    && write_i.data[1] && sense_i.supply_ok && !sense_i.dip_lower;

  sequence s_down_supply;
    mode_o == dpms_pkg::DPMS_SOFTDOWN && drive_o.supply_duty != 8'h00;
  endsequence
  sequence s_still_down;
    mode_o == dpms_pkg::DPMS_SOFTDOWN;
  endsequence

  a_por_no_ack: assert property (mode_o == dpms_pkg::DPMS_POR |->
    !ack_enable_o) else $error("ack given in power-on reset");
  a_loss_to_por: assert property (!sense_i.supply_ok |=>
    mode_o == dpms_pkg::DPMS_POR) else $error("supply loss kept mode");
  a_standby_float: assert property (mode_o == dpms_pkg::DPMS_STANDBY
    |-> !drive_o.line_oe && !drive_o.supply_oe && sync_unlock_flag_o)
    else $error("standby outputs wrong");
  a_supply_on_vert: assert property (mode_o == dpms_pkg::DPMS_SUPPLY_ON
    |-> supply_enable_o && vertical_enable_o && !drive_o.line_oe
    && !drive_o.supply_oe && sync_unlock_flag_o) else $error("supply mode");
  a_dip_blocks_rel: assert property (rel_wr && sense_i.dip_upper
    && mode_o == dpms_pkg::DPMS_SUPPLY_ON |=>
    mode_o != dpms_pkg::DPMS_SOFTSTART) else $error("release during dip");
  a_release_start: assert property (rel_wr && !sense_i.dip_upper
    && !prot_clear_i && !write_i.data[0]
    && mode_o == dpms_pkg::DPMS_SUPPLY_ON |=>
    mode_o == dpms_pkg::DPMS_SOFTSTART && sync_lock_loop_en_o
    && phase_loop_en_o) else $error("soft start not begun");
  a_lower_dip_stby: assert property (sense_i.dip_lower
    && sense_i.supply_ok && mode_o != dpms_pkg::DPMS_POR |=>
    mode_o == dpms_pkg::DPMS_STANDBY && !drive_o.line_oe)
    else $error("lower dip kept drives");
  a_down_order: assert property (s_still_down ##1 s_down_supply
    ##1 s_still_down |-> $stable(drive_o.line_duty))
    else $error("line ramped too early");
  a_protect_float: assert property (mode_o == dpms_pkg::DPMS_PROTECT
    |-> !drive_o.line_oe && !drive_o.supply_oe && !sync_unlock_oe_o
    && clamp_blank_out_o && !phase_loop_en_o) else $error("protect state");
  a_operate_exit: assert property (mode_o == dpms_pkg::DPMS_OPERATE
    ##1 mode_o != dpms_pkg::DPMS_OPERATE |-> mode_o inside
    {dpms_pkg::DPMS_SOFTDOWN, dpms_pkg::DPMS_PROTECT,
    dpms_pkg::DPMS_STANDBY, dpms_pkg::DPMS_POR}) else $error("bad exit");
endmodule : dpms_monitor

bind dpms_sequencer dpms_monitor mon (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .write_i(write_i),
  .sense_i(sense_i), .prot_clear_i(prot_clear_i),
  .ack_enable_o(ack_enable_o), .supply_enable_o(supply_enable_o),
  .vertical_enable_o(vertical_enable_o), .drive_o(drive_o),
  .sync_unlock_flag_o(sync_unlock_flag_o),
  .sync_unlock_oe_o(sync_unlock_oe_o),
  .clamp_blank_out_o(clamp_blank_out_o),
  .sync_lock_loop_en_o(sync_lock_loop_en_o),
  .phase_loop_en_o(phase_loop_en_o), .regs_valid_o(regs_valid_o),
  .mode_o(mode_o));

// [verification/dpms_host_model.sv]
/*
  Host controller model that issues decoded single-register writes.
  Assumes the sequencer takes write_o on the rising clock edge.
*/
`timescale 1ns/1ns
module dpms_host_model #(
  parameter int unsigned RELEASE_GAP = 200
) (
  input  wire logic             clock_i,
  output dpms_pkg::dpms_write_t write_o
);
  initial write_o = '0;

  // Idle fields carry inverted data so stale values cannot look valid.
  task automatic put(input logic bf, input logic [6:0] sad,
                     input logic [7:0] dat);
    @(negedge clock_i);
    write_o = {1'h1, bf, sad, dat};
    @(negedge clock_i);
    write_o = {1'h0, ~bf, ~sad, ~dat};
  endtask : put

  task automatic put_twice(input logic [7:0] dat);
    put(1'h0, 7'h1A, dat);
    put(1'h0, 7'h1A, dat);
  endtask : put_twice

  // The real start-up gap is far longer; it is scaled to keep runs short.
  task automatic hold_off;
    repeat (RELEASE_GAP) @(negedge clock_i);
  endtask : hold_off
endmodule : dpms_host_model

// [verification/deflection_power_mode_sequencer_test.sv]
/*
  Self-checking testbench of the mode sequencer with a host model.
  Assumes a 100 MHz clock and inputs driven on the falling edge.
*/
`timescale 1ns/1ns
module deflection_power_mode_sequencer_test;
  logic                  clock_i;
  logic                  reset_n_i;
  logic                  prot_clear_i;
  dpms_pkg::dpms_write_t write_i;
  dpms_pkg::dpms_sense_t sense_i;
  dpms_pkg::dpms_drive_t drive_o;
  dpms_pkg::dpms_mode_t  mode_o;
  logic                  ack_o, sup_o, vert_o, flag_o, flag_oe_o;
  logic                  blank_o, lock_o, phase_o, regs_o;
  logic [7:0]            held;
  int                    error_cnt = 0;
  int                    n_checks = 0;

  dpms_host_model host (.clock_i(clock_i), .write_o(write_i));
  dpms_sequencer dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .write_i(write_i), .sense_i(sense_i), .prot_clear_i(prot_clear_i),
    .ack_enable_o(ack_o), .supply_enable_o(sup_o),
    .vertical_enable_o(vert_o), .drive_o(drive_o),
    .sync_unlock_flag_o(flag_o), .sync_unlock_oe_o(flag_oe_o),
    .clamp_blank_out_o(blank_o), .sync_lock_loop_en_o(lock_o),
    .phase_loop_en_o(phase_o), .regs_valid_o(regs_o), .mode_o(mode_o));

  initial begin
    clock_i = 1'h0;
    forever #5 clock_i = ~clock_i;
  end

  task automatic end_sim;
    if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_mode(input dpms_pkg::dpms_mode_t exp);
    chk_val({5'h00, mode_o}, {5'h00, exp});
  endtask : chk_mode

  task automatic wait_for(input logic [7:0] sel);
    for (int i = 0; i < 30000; i++) begin
      @(negedge clock_i);
      if (sel == 8'h00 && drive_o.supply_duty === 8'h00) break;
      if (sel == 8'h01 && mode_o === dpms_pkg::DPMS_SUPPLY_ON) break;
      if (sel == 8'h02 && mode_o === dpms_pkg::DPMS_OPERATE) break;
    end
  endtask : wait_for

  task automatic t_power_up;
    host.put(1'h0, 7'h1A, 8'h00);
    chk_mode(dpms_pkg::DPMS_POR);
    chk_val(ack_o, 1'h0);
    sense_i.supply_ok = 1'h1;
    @(negedge clock_i);
    chk_mode(dpms_pkg::DPMS_STANDBY);
    chk_val({drive_o.line_oe, drive_o.supply_oe, sup_o, flag_o}, 8'h01);
  endtask : t_power_up

  task automatic t_supply_on;
    host.put(1'h1, 7'h1A, 8'h00);
    chk_mode(dpms_pkg::DPMS_SUPPLY_ON);
    chk_val({sup_o, vert_o, drive_o.line_oe, drive_o.supply_oe, flag_o},
            8'h19);
  endtask : t_supply_on

  task automatic t_soft_start;
    sense_i.dip_upper = 1'h1;
    host.put(1'h0, 7'h1A, 8'h02);
    chk_mode(dpms_pkg::DPMS_SUPPLY_ON);
    sense_i.dip_upper = 1'h0;
    host.hold_off();
    host.put(1'h0, 7'h1A, 8'h02);
    chk_mode(dpms_pkg::DPMS_SOFTSTART);
    chk_val({lock_o, phase_o, drive_o.line_oe, drive_o.supply_oe},
            8'h0F);
    host.put(1'h0, 7'h01, 8'h55);
    chk_val(regs_o, 1'h1);
    repeat (2500) @(negedge clock_i);
    chk_val(drive_o.line_duty inside {8'h19, 8'h1A}, 1'h1);
    chk_val(drive_o.supply_duty, drive_o.line_duty);
  endtask : t_soft_start

  task automatic t_soft_down;
    host.put(1'h0, 7'h1A, 8'h00);
    chk_mode(dpms_pkg::DPMS_SOFTDOWN);
    held = drive_o.line_duty;
    wait_for(8'h00);
    chk_val(drive_o.line_duty, held);
    wait_for(8'h01);
    chk_mode(dpms_pkg::DPMS_SUPPLY_ON);
    chk_val(drive_o.line_duty, 8'h00);
  endtask : t_soft_down

  task automatic t_clear_and_dip;
    host.put(1'h0, 7'h1A, 8'h02);
    prot_clear_i = 1'h1;
    @(negedge clock_i);
    prot_clear_i = 1'h0;
    chk_mode(dpms_pkg::DPMS_SOFTDOWN);
    sense_i.dip_lower = 1'h1;
    @(negedge clock_i);
    sense_i.dip_lower = 1'h0;
    chk_mode(dpms_pkg::DPMS_STANDBY);
    chk_val({drive_o.line_oe, drive_o.supply_oe, regs_o}, 8'h00);
    host.put_twice(8'h01);
    chk_mode(dpms_pkg::DPMS_STANDBY);
  endtask : t_clear_and_dip

  task automatic t_operate;
    host.put(1'h0, 7'h1A, 8'h00);
    host.hold_off();
    host.put(1'h0, 7'h1A, 8'h02);
    wait_for(8'h02);
    chk_mode(dpms_pkg::DPMS_OPERATE);
    chk_val(drive_o.line_duty, dpms_pkg::DUTY_MAX);
    chk_val(drive_o.supply_duty, dpms_pkg::DUTY_MAX);
    chk_val({flag_o, flag_oe_o, regs_o}, 8'h06);
    sense_i.sync_locked = 1'h1;
    @(negedge clock_i);
    chk_val(flag_o, 1'h0);
    host.put(1'h0, 7'h01, 8'h55);
    chk_val(regs_o, 1'h1);
    sense_i.fault = 1'h1;
    @(negedge clock_i);
    sense_i.fault = 1'h0;
    chk_mode(dpms_pkg::DPMS_PROTECT);
    chk_val({drive_o.line_oe, drive_o.supply_oe, flag_oe_o, blank_o, lock_o,
             phase_o, regs_o}, 8'h09);
    host.put(1'h0, 7'h1A, 8'h02);
    chk_mode(dpms_pkg::DPMS_SOFTSTART);
    wait_for(8'h02);
    sense_i.dip_upper = 1'h1;
    @(negedge clock_i);
    chk_mode(dpms_pkg::DPMS_SOFTDOWN);
    repeat (250) @(negedge clock_i);
    chk_val(drive_o.line_duty, dpms_pkg::DUTY_MAX);
    chk_val(drive_o.supply_duty < dpms_pkg::DUTY_MAX, 1'h1);
    sense_i.dip_lower = 1'h1;
    @(negedge clock_i);
    sense_i.dip_lower = 1'h0;
    sense_i.dip_upper = 1'h0;
    chk_mode(dpms_pkg::DPMS_STANDBY);
    chk_val({drive_o.line_oe, drive_o.supply_oe, regs_o}, 8'h00);
  endtask : t_operate

  task automatic t_supply_loss;
    sense_i.supply_ok = 1'h0;
    @(negedge clock_i);
    chk_mode(dpms_pkg::DPMS_POR);
    chk_val(ack_o, 1'h0);
  endtask : t_supply_loss

  // Margin of about a fifth over the expected run length, so that a hang
  // still ends well inside the cycle budget.
  initial begin
    #700000;
    error_cnt++;
    end_sim();
  end

  initial begin
    reset_n_i = 1'h0;
    prot_clear_i = 1'h0;
    sense_i = '0;
    repeat (8) @(negedge clock_i);
    reset_n_i = 1'h1;
    t_power_up();
    t_supply_on();
    t_soft_start();
    t_soft_down();
    t_clear_and_dip();
    t_operate();
    t_supply_loss();
    end_sim();
  end
endmodule : deflection_power_mode_sequencer_test
